// file: logic/afl_top.sv
// Post-conversion accumulator, averager and low-pass filter of the converter
// Functional notes
// - Mode 000 does no accumulation or filtering
// - Basic keeps accumulator, counter; tests every sample
// - Mode 001 adds each result to accumulator
// - Filtered output is accumulator shifted right
// - Accumulator and output stay right-justified always
// - Accumulate mode tests filtered output every sample
// - Counter increments per sample, holds at 0xFF
// - Accumulator is 18 bits; overflow above 262143
// - Each completed cycle outside mode 000 adds result into accumulator
// - Double sampling accumulates second minus first sample
// - Cycle is one or two conversions
// - At repeat target, mode decides accumulator clearing
// - Clear request clears accumulator, overflow, counter
// - Clear request bit self-clears when done
// - Clearing may take up to five cycles
// - Low-pass mode uses shift in its recurrence
// - Average mode tests once counter reaches target
// - Burst mode retriggers until counter equals target
// - Low-pass mode tests once counter reaches target
// - Overflow flag raises the threshold interrupt flag
`include "afl_regs.svh"
module afl_top import afl_pkg::*; #(
    parameter int RES_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // External trigger pin
    input wire logic ext_trig,
    // Conversion core
    output logic conv_start,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conversion_result,
    // Threshold logic
    output logic thr_req,
    output logic [17:0] thr_value,
    input wire logic thr_hit,
    output logic threshold_interrupt_flag
);

    // ----------------------------------------
    // Elaboration check
    // ----------------------------------------
    if (RES_W < 1 || RES_W > 16) begin : g_bad_res
        $error("afl_top: RES_W must be 1 to 16");
    end

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    afl_state_t state_r;
    afl_mode_t computation_mode_select_r;
    logic double_sample_enable_r;
    logic [2:0] shift_amount_r;
    logic [7:0] repeat_target_r;
    logic [7:0] sample_counter_r;
    logic [17:0] accumulator_value_r;
    logic [17:0] filtered_output_r;
    logic [15:0] previous_result_r;
    logic accumulator_overflow_flag_r;
    logic accumulator_clear_request_r;
    logic [2:0] clr_cnt_r;
    logic go_r;
    logic phase_r;
    logic trig_d_r;
    logic trig_sync;
    logic trig_edge;
    logic go_wr;
    logic accumulator_clear_request_wr;
    logic tif_wr;
    logic start;
    logic clr_done;
    logic cycle_done;
    logic burst_more;
    logic accumulating;
    logic at_target;
    logic start_clear;
    logic test_now;
    logic [7:0] cnt_nxt;
    logic [15:0] first_sample;
    logic [15:0] second_sample;
    logic [19:0] sample;
    logic [17:0] acc_nxt;
    logic [17:0] fltr_nxt;
    logic ovf;

    // ----------------------------------------
    // Pin synchroniser and trigger decode
    // ----------------------------------------
    afl_sync u_sync (
        .clk(clk),
        .reset_n(reset_n),
        .pin_in(ext_trig),
        .pin_sync(trig_sync)
    );

    // Rising edge of the synchronised pin
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trig_sync;
        end
    end

    // Register strobes that act besides storing
    assign trig_edge = trig_sync && !trig_d_r;
    assign go_wr = reg_wr && reg_addr == `AFL_OFS_CTRL && reg_wdata[`AFL_CTRL_GO_BIT];
    assign accumulator_clear_request_wr = reg_wr && reg_addr == `AFL_OFS_CTRL && reg_wdata[`AFL_CTRL_ACCUMULATOR_CLEAR_REQUEST_BIT];
    assign tif_wr = reg_wr && reg_addr == `AFL_OFS_STAT && reg_wdata[`AFL_STAT_TIF_BIT];

    // A trigger is taken only when idle; a trigger during a clear is dropped
    assign start = state_r == ST_IDLE && (go_wr || trig_edge) && !accumulator_clear_request_r;

    // ----------------------------------------
    // Sample selection and cycle bookkeeping
    // ----------------------------------------
    // With double sampling the first sample is the previously stored result
    assign second_sample = 16'(conversion_result);
    assign first_sample = double_sample_enable_r ? previous_result_r : second_sample;
    assign sample = double_sample_enable_r ?
        20'($signed({4'h0, second_sample}) - $signed({4'h0, first_sample})) :
        {4'h0, second_sample};

    // A cycle ends on every conversion, or every second one when doubled
    assign cycle_done = state_r == ST_CONV && conv_done &&
        (!double_sample_enable_r || phase_r);

    // Basic mode leaves the accumulator path idle
    assign accumulating = computation_mode_select_r != `AFL_MODE_BASIC;

    // Saturating sample count
    assign cnt_nxt = sample_counter_r == `AFL_CNT_MAX ? sample_counter_r :
        sample_counter_r + 8'h01;

    assign at_target = cnt_nxt >= repeat_target_r;

    // Average and burst restart from zero once the target was reached
    assign start_clear = start && sample_counter_r >= repeat_target_r &&
        (computation_mode_select_r == `AFL_MODE_AVG ||
         computation_mode_select_r == `AFL_MODE_BURST);

    // Burst keeps converting until the count meets the target
    assign burst_more = state_r == ST_CONV && conv_done &&
        computation_mode_select_r == `AFL_MODE_BURST &&
        (!cycle_done || cnt_nxt != repeat_target_r);

    // Threshold test scheduling per mode
    always_comb begin
        test_now = 1'b0;
        if (cycle_done) begin
            unique case (computation_mode_select_r)
                `AFL_MODE_BASIC: test_now = 1'b1;
                `AFL_MODE_ACCUM: test_now = 1'b1;
                `AFL_MODE_AVG: test_now = at_target;
                `AFL_MODE_BURST: test_now = at_target;
                `AFL_MODE_LPF: test_now = at_target;
                default: test_now = 1'b0;
            endcase
        end
    end

    // ----------------------------------------
    // Accumulator datapath
    // ----------------------------------------
    afl_accum u_accum (
        .mode(computation_mode_select_r),
        .shift_amount(shift_amount_r),
        .acc(start_clear ? 18'h00000 : accumulator_value_r),
        .sample(sample),
        .acc_nxt(acc_nxt),
        .fltr_nxt(fltr_nxt),
        .ovf(ovf)
    );

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    // Burst retriggers without software; other modes wait for a new trigger
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            conv_start <= 1'b0;
            go_r <= 1'b0;
        end else begin
            conv_start <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        conv_start <= 1'b1;
                        go_r <= 1'b1;
                        state_r <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    if (burst_more) begin
                        conv_start <= 1'b1;
                    end else if (conv_done) begin
                        go_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Double-sample phase and stored previous result
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= 1'b0;
            previous_result_r <= 16'h0000;
        end else if (state_r == ST_CONV && conv_done) begin
            phase_r <= double_sample_enable_r && !phase_r;
            previous_result_r <= phase_r ? previous_result_r : second_sample;
        end
    end

    // ----------------------------------------
    // Accumulator clear request
    // ----------------------------------------
    // Clear takes a fixed count so software polling sees a real busy window
    assign clr_done = accumulator_clear_request_r && clr_cnt_r == `AFL_CLR_CYCLES - 3'h1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accumulator_clear_request_r <= 1'b0;
            clr_cnt_r <= 3'h0;
        end else if (clr_done) begin
            accumulator_clear_request_r <= 1'b0;
            clr_cnt_r <= 3'h0;
        end else if (accumulator_clear_request_r) begin
            clr_cnt_r <= clr_cnt_r + 3'h1;
        end else if (accumulator_clear_request_wr) begin
            accumulator_clear_request_r <= 1'b1;
        end
    end

    // ----------------------------------------
    // Accumulator, counter and filtered output
    // ----------------------------------------
    // Software clear wins over a completing cycle in the same edge
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accumulator_value_r <= 18'h00000;
            sample_counter_r <= 8'h00;
            filtered_output_r <= 18'h00000;
        end else if (clr_done) begin
            accumulator_value_r <= 18'h00000;
            sample_counter_r <= 8'h00;
        end else if (cycle_done && accumulating) begin
            accumulator_value_r <= acc_nxt;
            sample_counter_r <= start_clear ? 8'h01 : cnt_nxt;
            filtered_output_r <= fltr_nxt;
        end else if (start_clear) begin
            accumulator_value_r <= 18'h00000;
            sample_counter_r <= 8'h00;
        end
    end

    // ----------------------------------------
    // Status flags
    // ----------------------------------------
    // Overflow is sticky until a software clear; a fresh overflow wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            accumulator_overflow_flag_r <= 1'b0;
        end else if (cycle_done && accumulating && ovf) begin
            accumulator_overflow_flag_r <= 1'b1;
        end else if (clr_done) begin
            accumulator_overflow_flag_r <= 1'b0;
        end
    end

    // Interrupt flag: threshold hit or overflow sets, write-one clears
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            threshold_interrupt_flag <= 1'b0;
        end else if (thr_hit || (cycle_done && accumulating && ovf)) begin
            threshold_interrupt_flag <= 1'b1;
        end else if (tif_wr) begin
            threshold_interrupt_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Threshold request to the comparator
    // ----------------------------------------
    // Basic mode hands over the raw sample, other modes the shifted value
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            thr_req <= 1'b0;
            thr_value <= 18'h00000;
        end else begin
            thr_req <= test_now;
            if (test_now) begin
                thr_value <= accumulating ? fltr_nxt : sample[17:0];
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            computation_mode_select_r <= `AFL_MODE_RST;
            double_sample_enable_r <= 1'b0;
            shift_amount_r <= `AFL_CRS_RST;
        end else if (reg_wr && reg_addr == `AFL_OFS_CTRL) begin
            computation_mode_select_r <= reg_wdata[`AFL_CTRL_MODE_LSB +: 3];
            double_sample_enable_r <= reg_wdata[`AFL_CTRL_DOUBLE_SAMPLE_ENABLE_BIT];
            shift_amount_r <= reg_wdata[`AFL_CTRL_CRS_LSB +: 3];
        end
    end

    // Repeat target; software keeps it at 2^shift for a true average
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            repeat_target_r <= `AFL_RPT_RST;
        end else if (reg_wr && reg_addr == `AFL_OFS_RPT) begin
            repeat_target_r <= reg_wdata[7:0];
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    // Data stand only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 16'h0000;
        end else if (!reg_rd) begin
            reg_rdata <= 16'h0000;
        end else begin
            unique case (reg_addr)
                `AFL_OFS_CTRL: reg_rdata <= {7'h00, accumulator_clear_request_r, go_r,
                    shift_amount_r, double_sample_enable_r, computation_mode_select_r};
                `AFL_OFS_RPT: reg_rdata <= {8'h00, repeat_target_r};
                `AFL_OFS_CNT: reg_rdata <= {8'h00, sample_counter_r};
                `AFL_OFS_ACC_LO: reg_rdata <= accumulator_value_r[15:0];
                `AFL_OFS_ACC_HI: reg_rdata <= {14'h0000, accumulator_value_r[17:16]};
                `AFL_OFS_FLTR: reg_rdata <= filtered_output_r[15:0];
                `AFL_OFS_STAT: reg_rdata <= {13'h0000, phase_r, threshold_interrupt_flag,
                    accumulator_overflow_flag_r};
                `AFL_OFS_PREV: reg_rdata <= previous_result_r;
                default: reg_rdata <= 16'h0000;
            endcase
        end
    end

endmodule

// file: logic/afl_regs.svh
// Register map, field positions, reset values and counts of the accumulator filter
`ifndef AFL_REGS_SVH
`define AFL_REGS_SVH

// ----------------------------------------
// Register offsets (word index on the port)
// ----------------------------------------
`define AFL_OFS_CTRL 4'h0
`define AFL_OFS_RPT 4'h1
`define AFL_OFS_CNT 4'h2
`define AFL_OFS_ACC_LO 4'h3
`define AFL_OFS_ACC_HI 4'h4
`define AFL_OFS_FLTR 4'h5
`define AFL_OFS_STAT 4'h6
`define AFL_OFS_PREV 4'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AFL_CTRL_MODE_LSB 0
`define AFL_CTRL_DOUBLE_SAMPLE_ENABLE_BIT 3
`define AFL_CTRL_CRS_LSB 4
`define AFL_CTRL_GO_BIT 7
`define AFL_CTRL_ACCUMULATOR_CLEAR_REQUEST_BIT 8
`define AFL_STAT_AOV_BIT 0
`define AFL_STAT_TIF_BIT 1
`define AFL_STAT_PHASE_BIT 2

// ----------------------------------------
// Mode codes and reset values
// ----------------------------------------
`define AFL_MODE_BASIC 3'h0
`define AFL_MODE_ACCUM 3'h1
`define AFL_MODE_AVG 3'h2
`define AFL_MODE_BURST 3'h3
`define AFL_MODE_LPF 3'h4
`define AFL_MODE_RST 3'h0
`define AFL_CRS_RST 3'h0
`define AFL_RPT_RST 8'h00
`define AFL_CNT_MAX 8'hff
`define AFL_ACC_MAX 20'h3ffff

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define AFL_CLR_CYCLES 3'h5

`endif

// file: logic/afl_pkg.sv
// Types and shared arithmetic of the accumulator filter
package afl_pkg;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef logic [2:0] afl_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_CONV} afl_state_t;

    // Logical right shift of the accumulator
    function automatic logic [17:0] afl_shr(input logic [17:0] val, input logic [2:0] sh);
        afl_shr = val >> sh;
    endfunction

endpackage

// file: logic/afl_sync.sv
// Two-flop synchroniser for a pin level
module afl_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Pin and synchronised level
    input wire logic pin_in,
    output logic pin_sync
);

    logic meta_r;

    // First flop feeds only the second
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            meta_r <= pin_in;
            pin_sync <= meta_r;
        end
    end

endmodule

// file: logic/afl_accum.sv
// Combinational next-value datapath of the 18-bit accumulator
`include "afl_regs.svh"
module afl_accum import afl_pkg::*; (
    // Configuration
    input wire afl_mode_t mode,
    input wire logic [2:0] shift_amount,
    // Operands
    input wire logic [17:0] acc,
    input wire logic [19:0] sample,
    // Results
    output logic [17:0] acc_nxt,
    output logic [17:0] fltr_nxt,
    output logic ovf
);

    logic [19:0] base;
    logic [19:0] sum;

    // Filter feedback term: only the low-pass mode bleeds off acc/2^crs
    always_comb begin
        base = {2'b00, acc};
        if (mode == `AFL_MODE_LPF) begin
            base = base - {{2{1'b0}}, afl_shr(acc, shift_amount)};
        end
        sum = base + sample;
    end

    // Wrapped result, overflow and shifted output
    assign acc_nxt = sum[17:0];
    assign ovf = $signed(sum) > $signed(`AFL_ACC_MAX);
    assign fltr_nxt = afl_shr(sum[17:0], shift_amount);

endmodule

// file: testbench/afl_top_properties.sv
// Port-level assertions of the accumulator filter, bound into afl_top
module afl_top_properties #(
    parameter int RES_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // Trigger and core
    input wire logic ext_trig,
    input wire logic conv_start,
    input wire logic conv_done,
    input wire logic [RES_W-1:0] conversion_result,
    // Threshold side
    input wire logic thr_req,
    input wire logic [17:0] thr_value,
    input wire logic thr_hit,
    input wire logic threshold_interrupt_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data not zero outside a read");
    cnt_width_a: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[15:8] == 8'h00)
        else $error("sample counter wider than 8 bits");
    acc_width_a: assert property (reg_rd && reg_addr == 4'h4 |=> reg_rdata[15:2] == 14'h0)
        else $error("accumulator wider than 18 bits");
    start_pulse_a: assert property (conv_start |=> !conv_start)
        else $error("conversion start longer than one cycle");
    // A start needs a write, a finished conversion (retrigger) or a pin edge
    start_cause_a: assert property (conv_start |-> $past(reg_wr) || $past(conv_done)
        || $past(ext_trig, 2) || $past(ext_trig, 3) || $past(ext_trig, 4) || $past(ext_trig, 5))
        else $error("conversion start without a trigger");
    req_cause_a: assert property (thr_req |-> $past(conv_done))
        else $error("threshold test not tied to a finished conversion");
    req_pulse_a: assert property (thr_req |=> !thr_req)
        else $error("threshold request longer than one cycle");
    tif_set_a: assert property (thr_hit |=> threshold_interrupt_flag)
        else $error("threshold hit did not raise the flag");
    // Flag is sticky until software writes one to its status bit
    tif_hold_a: assert property (threshold_interrupt_flag
        && !(reg_wr && reg_addr == 4'h6 && reg_wdata[1]) |=> threshold_interrupt_flag)
        else $error("threshold flag dropped without a clear");

    // Main scenarios
    cov_retrig_c: cover property (conv_done ##1 conv_start);
    cov_test_c: cover property (thr_req);
    cov_flag_c: cover property ($rose(threshold_interrupt_flag));
endmodule

bind afl_top afl_top_properties #(.RES_W(RES_W)) u_props (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .ext_trig(ext_trig), .conv_start(conv_start),
    .conv_done(conv_done), .conversion_result(conversion_result), .thr_req(thr_req),
    .thr_value(thr_value), .thr_hit(thr_hit),
    .threshold_interrupt_flag(threshold_interrupt_flag));

// file: testbench/afl_conv_model.sv
// Behavioural conversion core that answers each start after a set latency
module afl_conv_model #(
    parameter int RES_W = 12
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control from the bench
    input wire logic [RES_W-1:0] res_i,
    input wire logic [3:0] lat,
    // Core interface
    input wire logic conv_start,
    output logic conv_done,
    output logic [RES_W-1:0] conversion_result
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        conv_done = 1'b0;
        conversion_result = '0;
    end

    // Result is valid only beside done; otherwise show its inverse so stale reads show
    always @(posedge clk) begin
        if (reset_n && conv_start === 1'b1) begin
            repeat (lat) @(posedge clk);
            conv_done <= 1'b1;
            conversion_result <= res_i;
            @(posedge clk);
            conv_done <= 1'b0;
            conversion_result <= ~res_i;
        end
    end
endmodule

// file: testbench/tb_adc_result_accumulator_filter.sv
// Self-checking bench of the accumulator filter over its register port
module tb_adc_result_accumulator_filter;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, reset_n, reg_wr, reg_rd, ext_trig, thr_hit, hit_en;
    logic conv_start, conv_done, thr_req, tif;
    logic [3:0] reg_addr, lat;
    logic [15:0] reg_wdata, reg_rdata;
    logic [11:0] res, conversion_result;
    logic [17:0] thr_value;
    int err_count, samples_checked, ndone, nreq, nstart, n0, i;

    // ----------------------------------------
    // Design, core model, clock
    // ----------------------------------------
    afl_top #(.RES_W(12)) uut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_trig(ext_trig), .conv_start(conv_start), .conv_done(conv_done),
        .conversion_result(conversion_result), .thr_req(thr_req), .thr_value(thr_value),
        .thr_hit(thr_hit), .threshold_interrupt_flag(tif));
    afl_conv_model #(.RES_W(12)) core (.clk(clk), .reset_n(reset_n), .res_i(res), .lat(lat),
        .conv_start(conv_start), .conv_done(conv_done), .conversion_result(conversion_result));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Event counters and a threshold unit that hits on request when enabled
    always @(posedge clk) begin
        if (conv_done === 1'b1) ndone++;
        if (thr_req === 1'b1) nreq++;
        if (conv_start === 1'b1) nstart++;
        thr_hit <= (thr_req === 1'b1) && hit_en;
    end

    // ----------------------------------------
    // Access and check tasks
    // ----------------------------------------
    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rc(input logic [3:0] a, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        chk({2'b00, v}, {2'b00, e});
    endtask

    // Start by write or pin, then wait for n finished conversions
    task automatic trig(input logic [15:0] ctrl, input int n, input bit ext);
        int d0, k;
        d0 = ndone;
        k = 0;
        if (ext) begin
            @(posedge clk);
            ext_trig <= 1'b1;
            repeat (3) @(posedge clk);
            ext_trig <= 1'b0;
        end else begin
            wr(4'h0, ctrl | 16'h0080);
        end
        while (ndone < d0 + n && k < 200) begin
            @(posedge clk);
            k++;
        end
        repeat (3) @(posedge clk);
        chk(18'(ndone - d0), 18'(n));
    endtask

    // Clear also rewrites the mode; the pending bit must drop within a few cycles
    task automatic clr(input logic [15:0] ctrl);
        logic [15:0] v;
        int k;
        wr(4'h0, ctrl | 16'h0100);
        rd(4'h0, v);
        chk({17'h0, v[8]}, 18'h1);
        k = 0;
        while (v[8] !== 1'b0 && k < 8) begin
            rd(4'h0, v);
            k++;
        end
        chk(18'(k < 4), 18'h1);
        rc(4'h3, 16'h0000);
        rc(4'h2, 16'h0000);
    endtask

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {reg_wr, reg_rd, ext_trig, thr_hit, hit_en} = 5'h00;
        {reg_addr, reg_wdata, res} = '0;
        {err_count, samples_checked, ndone, nreq, nstart} = '0;
        lat = 4'h2;
        reset_n = 1'b0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        // Reset values, unmapped index
        for (i = 0; i < 8; i++) rc(4'(i), 16'h0000);
        wr(4'hc, 16'h00ff);
        rc(4'hc, 16'h0000);
        // Accumulate, shift 2, slow core, one pin trigger, threshold hit
        lat = 4'h6;
        hit_en = 1'b1;
        clr(16'h0021);
        res = 12'h064;
        trig(16'h0021, 1, 0);
        res = 12'h0c8;
        trig(16'h0021, 1, 1);
        res = 12'h12c;
        trig(16'h0021, 1, 0);
        rc(4'h3, 16'h0258);
        rc(4'h2, 16'h0003);
        rc(4'h5, 16'h0096);
        chk(thr_value, 18'h00096);
        rc(4'h6, 16'h0002);
        wr(4'h6, 16'h0002);
        rc(4'h6, 16'h0000);
        hit_en = 1'b0;
        // Basic leaves accumulator and counter, still tests the sample
        n0 = nreq;
        wr(4'h0, 16'h0020);
        trig(16'h0020, 1, 0);
        rc(4'h3, 16'h0258);
        rc(4'h2, 16'h0003);
        chk(thr_value, 18'h0012c);
        chk(18'(nreq - n0), 18'h1);
        // Counter saturation with a fast core
        lat = 4'h1;
        clr(16'h0001);
        res = 12'h001;
        for (i = 0; i < 256; i++) trig(16'h0001, 1, 0);
        rc(4'h2, 16'h00ff);
        rc(4'h3, 16'h0100);
        // Overflow past 262143, then clear
        clr(16'h0001);
        res = 12'hfff;
        for (i = 0; i < 64; i++) trig(16'h0001, 1, 0);
        rc(4'h6, 16'h0000);
        trig(16'h0001, 1, 0);
        rc(4'h6, 16'h0003);
        rc(4'h3, 16'h0fbf);
        clr(16'h0001);
        rc(4'h6, 16'h0002);
        wr(4'h6, 16'h0002);
        // Double sampling: second minus first, one cycle per pair
        lat = 4'h3;
        clr(16'h0009);
        res = 12'h064;
        trig(16'h0009, 1, 0);
        rc(4'h6, 16'h0004);
        rc(4'h2, 16'h0000);
        res = 12'h15e;
        trig(16'h0009, 1, 0);
        rc(4'h3, 16'h00fa);
        rc(4'h2, 16'h0001);
        rc(4'h7, 16'h0064);
        // Average: repeat target equals two to the shift
        wr(4'h1, 16'h0004);
        clr(16'h0022);
        n0 = nreq;
        res = 12'h028;
        for (i = 0; i < 4; i++) trig(16'h0022, 1, 0);
        chk(18'(nreq - n0), 18'h1);
        rc(4'h3, 16'h00a0);
        rc(4'h5, 16'h0028);
        res = 12'h008;
        trig(16'h0022, 1, 0);
        rc(4'h3, 16'h0008);
        rc(4'h2, 16'h0001);
        // Burst: one start gives the whole burst, the next start clears
        wr(4'h1, 16'h0002);
        clr(16'h0013);
        n0 = nstart;
        res = 12'h01e;
        trig(16'h0013, 2, 0);
        chk(18'(nstart - n0), 18'h2);
        rc(4'h3, 16'h003c);
        rc(4'h2, 16'h0002);
        res = 12'h032;
        trig(16'h0013, 2, 0);
        rc(4'h3, 16'h0064);
        rc(4'h5, 16'h0032);
        // Low-pass recurrence with shift 1
        wr(4'h1, 16'h0001);
        clr(16'h0014);
        res = 12'h064;
        trig(16'h0014, 1, 0);
        rc(4'h3, 16'h0064);
        trig(16'h0014, 1, 0);
        rc(4'h3, 16'h0096);
        rc(4'h5, 16'h004b);
        chk(thr_value, 18'h0004b);
        give_verdict();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
